// *** flash_host_model.sv ***
// Purpose: host side of the flash bus for the query responder
// Assumes: every call starts one delay after a rising edge
// Notes:   released lines show inverted last values
`default_nettype none
`include "flash_query_consts.svh"
module flash_host_model (
  input  wire logic                     clock,
  input  wire logic                     byteMode,
  output var  flash_query_pkg::busReq_t busReq
);
  timeunit 1ns;
  timeprecision 1ps;

  initial busReq = '0;

  task automatic access(input logic w, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    busReq.wrStb = w;
    busReq.rdStb = !w;
    busReq.addr  = a;
    busReq.wdata = d;
    @(posedge clock);
    #1;
  endtask

  task automatic idle();
    busReq.wrStb = 1'b0;
    busReq.rdStb = 1'b0;
    busReq.addr  = ~busReq.addr;
    busReq.wdata = ~busReq.wdata;
    @(posedge clock);
    #1;
  endtask

  // wild lets a scenario break the word-mode address limit on purpose
  task automatic read(input logic [`ADDR_W-1:0] a, input logic wild);
    logic [`ADDR_W-1:0] x;
    x = a;
    if (!byteMode && !wild) x[`ADDR_W-1:7] = '0;
    access(1'b0, x, ~busReq.wdata);
  endtask

  task automatic query();
    access(1'b1, byteMode ? 21'h0_00AA : 21'h0_0055, 16'h0098);
  endtask

  task automatic reset_cmd(input logic [`ADDR_W-1:0] a);
    access(1'b1, a, 16'h00F0);
  endtask
endmodule
`default_nettype wire

// *** flash_query_consts.svh ***
// Purpose: shared constants of the query responder
// Assumes: word and byte addresses share one bus field
// Notes:   zero table entries are named too and share QV_ZERO
`ifndef FLASH_QUERY_CONSTS_SVH
`define FLASH_QUERY_CONSTS_SVH

`define ADDR_W      21
`define DATA_W      16
`define IDX_W       7
`define CMD_W       8
`define CMD_QUERY   8'h98
`define CMD_RESET   8'hF0
`define QRY_WADDR   8'h55
`define QRY_BADDR   9'h0AA
`define QI_Q        7'h10
`define QI_R        7'h11
`define QI_Y        7'h12
`define QI_PCS      7'h13
`define QI_PCS_HI   7'h14
`define QI_PEXT     7'h15
`define QI_PEXT_HI  7'h16
`define QI_ALT      7'h17
`define QI_VMIN     7'h1B
`define QI_VMAX     7'h1C
`define QI_VPP      7'h1D
`define QI_TWR      7'h1F
`define QI_TBE      7'h21
`define QI_MWR      7'h23
`define QI_MBE      7'h25
`define QI_SIZE     7'h27
`define QI_IFD      7'h28
`define QI_BUF      7'h2A
`define QI_NREG     7'h2C
`define QI_R1       7'h2F
`define QI_R2A      7'h31
`define QI_R2C      7'h33
`define QI_R3       7'h37
`define QI_R4A      7'h39
`define QI_R4D      7'h3C
`define QV_Q        16'h0051
`define QV_R        16'h0052
`define QV_Y        16'h0059
`define QV_PCS      16'h0002
`define QV_PEXT     16'h0040
`define QV_VMIN     16'h0027
`define QV_VMAX     16'h0036
`define QV_TWR      16'h0004
`define QV_TBE      16'h000A
`define QV_MWR      16'h0005
`define QV_MBE      16'h0004
`define QV_SIZE     16'h0015
`define QV_IFD      16'h0002
`define QV_NREG     16'h0004
`define QV_R1       16'h0040
`define QV_R2A      16'h0001
`define QV_R2C      16'h0020
`define QV_R3       16'h0080
`define QV_R4A      16'h001E
`define QV_R4D      16'h0001
`define QV_ZERO     16'h0000

`endif

// *** flash_query_pkg.sv ***
// Purpose: types of the query responder
// Assumes: constants header included first
// Notes:   no functions here, only carriers
`default_nettype none
`include "flash_query_consts.svh"
package flash_query_pkg;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_AUTOSEL, MODE_QUERY} devMode_t;

  typedef struct packed {
    logic                wrStb;
    logic                rdStb;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  wdata;
  } busReq_t;

  typedef struct packed {
    logic isQuery;
    logic isReset;
  } cmdKind_t;

  typedef struct packed {
    logic               valid;
    logic [`DATA_W-1:0] data;
  } rdResp_t;

endpackage
`default_nettype wire

// *** flash_query_responder.sv ***
// Purpose: query mode state and table read path of the flash
// Assumes: one-cycle strobes; read and write never share a cycle
// Notes:   table answers come two cycles after the read strobe
`default_nettype none
`include "flash_query_consts.svh"
module flash_query_responder (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire flash_query_pkg::busReq_t  busReq,
  input  wire logic                      byteMode,
  input  wire logic                      arrayReady,
  input  wire logic                      autoselEnter,
  output var  flash_query_pkg::rdResp_t  rdResp,
  output var  logic                      queryActive,
  output var  logic                      autoselActive
);

  flash_query_pkg::devMode_t mode;
  flash_query_pkg::devMode_t retMode;
  flash_query_pkg::devMode_t next_mode;
  flash_query_pkg::devMode_t next_retMode;
  flash_query_pkg::cmdKind_t cmd;

  logic               rdTake;
  logic [`IDX_W-1:0]  rdIndex;
  logic [`DATA_W-1:0] romEntry;
  logic               rdPend;
  logic               hiClear;
  logic               byteSel;
  logic               oddByte;

  // word location of an access in either bus width
  function automatic logic [`IDX_W-1:0] tableIndex(
    input logic [`ADDR_W-1:0] a,
    input logic               bm
  );
    tableIndex = bm ? a[`IDX_W:1] : a[`IDX_W-1:0];
  endfunction

  // address bits above the table must be zero; word mode leaves bit 20 unchecked
  function automatic logic upperClear(
    input logic [`ADDR_W-1:0] a,
    input logic               bm
  );
    if (bm) begin
      upperClear = (a[`ADDR_W-1:`IDX_W+1] == '0);
    end else begin
      upperClear = (a[`ADDR_W-2:`IDX_W] == '0);
    end
  endfunction

  query_cmd_decoder cmdDec (
    .byteMode (byteMode),
    .busReq   (busReq),
    .cmd      (cmd)
  );

  // mode transitions; a command write wins over autoselect entry
  always_comb begin
    next_mode = mode;
    next_retMode = retMode;
    unique case (mode)
      flash_query_pkg::MODE_ARRAY: begin
        if (cmd.isQuery && arrayReady) begin
          next_mode = flash_query_pkg::MODE_QUERY;
          next_retMode = flash_query_pkg::MODE_ARRAY;
        end else if (autoselEnter && !busReq.wrStb) begin
          next_mode = flash_query_pkg::MODE_AUTOSEL;
        end
      end
      flash_query_pkg::MODE_AUTOSEL: begin
        if (cmd.isQuery) begin
          next_mode = flash_query_pkg::MODE_QUERY;
          next_retMode = flash_query_pkg::MODE_AUTOSEL;
        end else if (cmd.isReset) begin
          next_mode = flash_query_pkg::MODE_ARRAY;
        end
      end
      flash_query_pkg::MODE_QUERY: begin
        if (cmd.isReset) begin
          next_mode = retMode;
        end
      end
      default: begin
        next_mode = flash_query_pkg::MODE_ARRAY;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode          <= flash_query_pkg::MODE_ARRAY;
      queryActive   <= 1'b0;
      autoselActive <= 1'b0;
    end else begin
      mode          <= next_mode;
      queryActive   <= (next_mode == flash_query_pkg::MODE_QUERY);
      autoselActive <= (next_mode == flash_query_pkg::MODE_AUTOSEL);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      retMode <= flash_query_pkg::MODE_ARRAY;
    end else begin
      retMode <= next_retMode;
    end
  end

  // reads are answered only while in query mode
  assign rdTake = busReq.rdStb && queryActive;
  assign rdIndex = tableIndex(busReq.addr, byteMode);

  query_table_rom tableRom (
    .clock (clock),
    .nrst  (nrst),
    .en    (rdTake),
    .index (rdIndex),
    .entry (romEntry)
  );

  // access qualifiers travel alongside the table lookup
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdPend  <= 1'b0;
      hiClear <= 1'b0;
      byteSel <= 1'b0;
      oddByte <= 1'b0;
    end else begin
      rdPend  <= rdTake;
      hiClear <= upperClear(busReq.addr, byteMode);
      byteSel <= byteMode;
      oddByte <= byteMode && busReq.addr[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdResp.valid <= 1'b0;
    end else begin
      rdResp.valid <= rdPend;
    end
  end

  // data holds between answers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdResp.data <= `QV_ZERO;
    end else if (rdPend) begin
      if (!hiClear) begin
        rdResp.data <= `QV_ZERO;
      end else if (byteSel) begin
        // odd byte is the upper half, always zero
        rdResp.data <= oddByte ? `QV_ZERO : {8'h00, romEntry[7:0]};
      end else begin
        rdResp.data <= romEntry;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property tblWord(logic [`IDX_W-1:0] i, logic [`DATA_W-1:0] v);
    busReq.rdStb && queryActive && !byteMode && busReq.addr == {14'h0000, i}
      |-> ##2 rdResp.valid && rdResp.data == v;
  endproperty

  property tblByte(logic [`IDX_W-1:0] i, logic [`DATA_W-1:0] v);
    busReq.rdStb && queryActive && byteMode && busReq.addr == {13'h0000, i, 1'b0}
      |-> ##2 rdResp.valid && rdResp.data == v;
  endproperty

  query_entry_a: assert property (
    cmd.isQuery && !queryActive && !autoselActive && arrayReady
      |=> queryActive && !autoselActive ##1 (queryActive || $past(cmd.isReset)))
    else $error("query command from array not taken");

  busy_ignore_a: assert property (
    cmd.isQuery && !queryActive && !autoselActive && !arrayReady
      |=> !queryActive)
    else $error("query entered while array not ready");

  read_latency_a: assert property (
    rdResp.valid == $past(rdTake, 2))
    else $error("table answer not two cycles after read");

  exit_stop_a: assert property (
    (cmd.isReset && queryActive) ##1 busReq.rdStb |-> ##2 !rdResp.valid)
    else $error("table data after reset command");

  autosel_query_a: assert property (
    cmd.isQuery && autoselActive |=> queryActive && retMode == flash_query_pkg::MODE_AUTOSEL)
    else $error("query from autoselect not taken");

  autosel_return_a: assert property (
    cmd.isReset && queryActive && retMode == flash_query_pkg::MODE_AUTOSEL
      |=> autoselActive && !queryActive)
    else $error("reset did not return to autoselect");

  array_return_a: assert property (
    cmd.isReset && (autoselActive || retMode == flash_query_pkg::MODE_ARRAY)
      |=> !autoselActive && !queryActive)
    else $error("reset did not return to array");

  qry_string_a: assert property (tblWord(`QI_Q, `QV_Q))
    else $error("bad Q entry");
  qry_last_a: assert property (tblWord(`QI_Y, `QV_Y))
    else $error("bad Y entry");
  cmd_set_a: assert property (tblWord(`QI_PCS, `QV_PCS))
    else $error("bad command set entry");
  ext_ptr_a: assert property (tblWord(`QI_PEXT, `QV_PEXT))
    else $error("bad extended pointer entry");
  alt_zero_a: assert property (tblWord(`QI_ALT, `QV_ZERO))
    else $error("alternate set not zero");
  supply_max_a: assert property (tblWord(`QI_VMAX, `QV_VMAX))
    else $error("bad supply maximum");
  vpp_zero_a: assert property (tblWord(`QI_VPP, `QV_ZERO))
    else $error("programming supply not zero");
  erase_typ_a: assert property (tblWord(`QI_TBE, `QV_TBE))
    else $error("bad typical erase timeout");
  write_max_a: assert property (tblWord(`QI_MWR, `QV_MWR))
    else $error("bad write multiplier");
  dev_size_a: assert property (tblWord(`QI_SIZE, `QV_SIZE))
    else $error("bad size exponent");
  buf_zero_a: assert property (tblWord(`QI_BUF, `QV_ZERO))
    else $error("buffer size not zero");
  region_count_a: assert property (tblWord(`QI_NREG, `QV_NREG))
    else $error("bad region count");
  region_one_a: assert property (tblWord(`QI_R1, `QV_R1))
    else $error("bad region one size");
  region_two_a: assert property (tblWord(`QI_R2C, `QV_R2C))
    else $error("bad region two size");
  region_three_a: assert property (tblWord(`QI_R3, `QV_R3))
    else $error("bad region three size");
  region_four_a: assert property (tblWord(`QI_R4D, `QV_R4D))
    else $error("bad region four size");
  byte_lane_a: assert property (tblByte(`QI_Y, `QV_Y))
    else $error("bad byte mode entry");
  qry_mid_a: assert property (tblWord(`QI_R, `QV_R))
    else $error("bad R entry");
  supply_min_a: assert property (tblWord(`QI_VMIN, `QV_VMIN))
    else $error("bad supply minimum");
  write_typ_a: assert property (tblWord(`QI_TWR, `QV_TWR))
    else $error("bad typical write timeout");
  erase_max_a: assert property (tblWord(`QI_MBE, `QV_MBE))
    else $error("bad erase multiplier");
  iface_desc_a: assert property (tblWord(`QI_IFD, `QV_IFD))
    else $error("bad interface description");
  region_two_blocks_a: assert property (tblWord(`QI_R2A, `QV_R2A))
    else $error("bad region two block count");
  region_four_blocks_a: assert property (tblWord(`QI_R4A, `QV_R4A))
    else $error("bad region four block count");
  cmd_upper_a: assert property (tblWord(`QI_PCS_HI, `QV_ZERO))
    else $error("command set upper word not zero");
  ext_upper_a: assert property (tblWord(`QI_PEXT_HI, `QV_ZERO))
    else $error("extended pointer upper word not zero");
  byte_count_a: assert property (tblByte(`QI_NREG, `QV_NREG))
    else $error("bad byte mode region count");

  byte_odd_a: assert property (
    busReq.rdStb && queryActive && byteMode && busReq.addr[0]
      |-> ##2 rdResp.valid && rdResp.data == `QV_ZERO)
    else $error("odd byte lane not zero");

  idle_read_a: assert property (
    busReq.rdStb && !queryActive
      |-> ##2 !rdResp.valid)
    else $error("read answered outside query mode");

  query_hold_a: assert property (
    queryActive && !cmd.isReset
      |=> queryActive)
    else $error("query mode left without reset command");

  autosel_hold_a: assert property (
    autoselActive && !cmd.isQuery && !cmd.isReset
      |=> autoselActive)
    else $error("autoselect left without command");

  mode_exclusive_a: assert property (
    !(queryActive && autoselActive))
    else $error("query and autoselect both active");

  high_addr_a: assert property (
    busReq.rdStb && queryActive && !byteMode
      && busReq.addr == {13'h0000, 1'b1, `QI_Q}
      |-> ##2 rdResp.valid && rdResp.data == `QV_ZERO)
    else $error("high address bits not forcing zero");

  cover_array_entry: cover property (
    cmd.isQuery && !autoselActive && !queryActive ##1 queryActive);
  cover_autosel_entry: cover property (
    cmd.isQuery && autoselActive ##1 queryActive);
  cover_autosel_back: cover property (
    cmd.isReset && queryActive ##1 autoselActive);
  cover_byte_read: cover property (
    busReq.rdStb && queryActive && byteMode ##2 rdResp.valid);
  cover_array_back: cover property (
    cmd.isReset && queryActive && retMode == flash_query_pkg::MODE_ARRAY ##1 !queryActive);

endmodule
`default_nettype wire

// *** flash_query_responder_tb_top.sv ***
// Purpose: self-checking bench of the query responder
// Assumes: answers two cycles after a read, flags one edge after a write
// Notes:   a cycle model tracks mode and expected answers
`default_nettype none
`include "flash_query_consts.svh"
module flash_query_responder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      clock, nrst, byteMode, arrayReady, autoselEnter;
  logic                      queryActive, autoselActive, pv, take;
  logic [`DATA_W-1:0]        pd, d;
  logic [31:0]               rnd;
  int                        miscompares, checked;
  flash_query_pkg::busReq_t  busReq;
  flash_query_pkg::rdResp_t  rdResp;
  flash_query_pkg::devMode_t mode, back;

  flash_query_responder i_flash_query_responder (.clock(clock), .nrst(nrst), .busReq(busReq),
    .byteMode(byteMode), .arrayReady(arrayReady), .autoselEnter(autoselEnter), .rdResp(rdResp),
    .queryActive(queryActive), .autoselActive(autoselActive));
  flash_host_model i_flash_host_model (.clock(clock), .byteMode(byteMode), .busReq(busReq));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [`DATA_W-1:0] tbl(input logic [6:0] i);
    case (i)
      7'h10: tbl = 16'h0051;
      7'h11: tbl = 16'h0052;
      7'h12: tbl = 16'h0059;
      7'h13: tbl = 16'h0002;
      7'h15: tbl = 16'h0040;
      7'h1B: tbl = 16'h0027;
      7'h1C: tbl = 16'h0036;
      7'h1F: tbl = 16'h0004;
      7'h21: tbl = 16'h000A;
      7'h23: tbl = 16'h0005;
      7'h25: tbl = 16'h0004;
      7'h27: tbl = 16'h0015;
      7'h28: tbl = 16'h0002;
      7'h2C: tbl = 16'h0004;
      7'h2F: tbl = 16'h0040;
      7'h31: tbl = 16'h0001;
      7'h33: tbl = 16'h0020;
      7'h37: tbl = 16'h0080;
      7'h39: tbl = 16'h001E;
      7'h3C: tbl = 16'h0001;
      default: tbl = 16'h0000;
    endcase
  endfunction

  function automatic logic [`DATA_W-1:0] expd(input logic [`ADDR_W-1:0] a, input logic bm);
    if (bm) expd = (a[20:8] != '0 || a[0]) ? 16'h0000 : tbl(a[7:1]);
    else expd = (a[19:7] != '0) ? 16'h0000 : tbl(a[6:0]);
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic ok, input string m);
    checked++;
    if (!ok) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clock) begin
    take = busReq.rdStb && mode == flash_query_pkg::MODE_QUERY && nrst;
    d = expd(busReq.addr, byteMode);
    if (!nrst) begin
      mode = flash_query_pkg::MODE_ARRAY;
      pv = 1'b0;
      pd = '0;
    end else if (busReq.wrStb && busReq.wdata[7:0] == 8'h98
                 && (byteMode ? busReq.addr[8:0] == 9'h0AA : busReq.addr[7:0] == 8'h55)
                 && (mode == flash_query_pkg::MODE_AUTOSEL || (mode == flash_query_pkg::MODE_ARRAY && arrayReady))) begin
      back = mode;
      mode = flash_query_pkg::MODE_QUERY;
    end else if (busReq.wrStb && busReq.wdata[7:0] == 8'hF0) begin
      mode = (mode == flash_query_pkg::MODE_QUERY) ? back : flash_query_pkg::MODE_ARRAY;
    end else if (!busReq.wrStb && autoselEnter && mode == flash_query_pkg::MODE_ARRAY) begin
      mode = flash_query_pkg::MODE_AUTOSEL;
    end
    #2;
    chk(queryActive === (mode == flash_query_pkg::MODE_QUERY)
        && autoselActive === (mode == flash_query_pkg::MODE_AUTOSEL), "mode flags");
    chk(rdResp.valid === pv && rdResp.data === pd, "read answer");
    if (take) pd = d;
    pv = take;
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    byteMode = 1'b0;
    arrayReady = 1'b1;
    autoselEnter = 1'b0;
    miscompares = 0;
    checked = 0;
    rnd = 32'hb2a9;
    mode = flash_query_pkg::MODE_ARRAY;
    back = flash_query_pkg::MODE_ARRAY;
    pv = 1'b0;
    pd = '0;
    repeat (6) @(posedge clock);
    #1;
    nrst = 1'b1;
    i_flash_host_model.read(21'h0_0010, 1'b0);
    arrayReady = 1'b0;
    i_flash_host_model.query();
    arrayReady = 1'b1;
    i_flash_host_model.query();
    for (int i = 0; i < 8'h48; i++) i_flash_host_model.read(`ADDR_W'(i), 1'b0);
    i_flash_host_model.query();
    i_flash_host_model.read(21'h0_0090, 1'b1);
    i_flash_host_model.read(21'h0_0011, 1'b0);
    i_flash_host_model.reset_cmd(21'h1_5A3C);
    i_flash_host_model.read(21'h0_0010, 1'b0);
    note("word table");
    byteMode = 1'b1;
    i_flash_host_model.query();
    for (int i = 0; i < 8'h90; i++) i_flash_host_model.read(`ADDR_W'(i), 1'b0);
    i_flash_host_model.read(21'h0_0120, 1'b0);
    i_flash_host_model.reset_cmd(21'h0_0AAA);
    note("byte table");
    byteMode = 1'b0;
    autoselEnter = 1'b1;
    i_flash_host_model.access(1'b1, 21'h1_2345, 16'h0012);
    i_flash_host_model.idle();
    autoselEnter = 1'b0;
    i_flash_host_model.query();
    i_flash_host_model.read(21'h0_0012, 1'b0);
    i_flash_host_model.reset_cmd(21'h0_0000);
    i_flash_host_model.read(21'h0_0010, 1'b0);
    i_flash_host_model.reset_cmd(21'h0_7777);
    note("autoselect");
    repeat (400) begin
      rnd = lfsr(rnd);
      byteMode = rnd[5] & rnd[12];
      arrayReady = rnd[6] | rnd[7];
      autoselEnter = rnd[9] & rnd[10];
      case (rnd[2:0])
        3'h0: i_flash_host_model.query();
        3'h1: i_flash_host_model.reset_cmd(rnd[31:11]);
        3'h2: i_flash_host_model.access(1'b1, rnd[20:0], {8'h00, rnd[15:8]});
        3'h3: i_flash_host_model.idle();
        default: i_flash_host_model.read(rnd[3] ? rnd[20:0] : {13'h0000, rnd[15:8]}, rnd[4]);
      endcase
    end
    note("random");
    byteMode = 1'b0;
    arrayReady = 1'b1;
    autoselEnter = 1'b0;
    i_flash_host_model.query();
    i_flash_host_model.read(21'h0_0010, 1'b0);
    nrst = 1'b0;
    i_flash_host_model.idle();
    i_flash_host_model.idle();
    nrst = 1'b1;
    i_flash_host_model.read(21'h0_0010, 1'b0);
    repeat (3) i_flash_host_model.idle();
    note("reset");
    end_of_test();
  end
endmodule
`default_nettype wire

// *** query_cmd_decoder.sv ***
// Purpose: classifies a bus write as query or reset command
// Assumes: only data lanes 7..0 carry the command
// Notes:   purely combinational
`default_nettype none
`include "flash_query_consts.svh"
module query_cmd_decoder (
  input  wire logic                     byteMode,
  input  wire flash_query_pkg::busReq_t busReq,
  output var  flash_query_pkg::cmdKind_t cmd
);

  logic addrHit;

  always_comb begin
    if (byteMode) begin
      addrHit = (busReq.addr[8:0] == `QRY_BADDR);
    end else begin
      addrHit = (busReq.addr[7:0] == `QRY_WADDR);
    end
  end

  always_comb begin
    cmd.isQuery = busReq.wrStb && addrHit
                  && (busReq.wdata[`CMD_W-1:0] == `CMD_QUERY);
    // address is don't care here
    cmd.isReset = busReq.wrStb
                  && (busReq.wdata[`CMD_W-1:0] == `CMD_RESET);
  end

endmodule
`default_nettype wire

// *** query_table_rom.sv ***
// Purpose: query table lookup with registered read data
// Assumes: index is a word location
// Notes:   anything outside the named entries reads zero
`default_nettype none
`include "flash_query_consts.svh"
module query_table_rom (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               en,
  input  wire logic [`IDX_W-1:0]  index,
  output var  logic [`DATA_W-1:0] entry
);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      entry <= `QV_ZERO;
    end else if (en) begin
      unique case (index)
        `QI_Q:    entry <= `QV_Q;
        `QI_R:    entry <= `QV_R;
        `QI_Y:    entry <= `QV_Y;
        `QI_PCS:  entry <= `QV_PCS;
        `QI_PEXT: entry <= `QV_PEXT;
        `QI_VMIN: entry <= `QV_VMIN;
        `QI_VMAX: entry <= `QV_VMAX;
        `QI_TWR:  entry <= `QV_TWR;
        `QI_TBE:  entry <= `QV_TBE;
        `QI_MWR:  entry <= `QV_MWR;
        `QI_MBE:  entry <= `QV_MBE;
        `QI_SIZE: entry <= `QV_SIZE;
        `QI_IFD:  entry <= `QV_IFD;
        `QI_NREG: entry <= `QV_NREG;
        `QI_R1:   entry <= `QV_R1;
        `QI_R2A:  entry <= `QV_R2A;
        `QI_R2C:  entry <= `QV_R2C;
        `QI_R3:   entry <= `QV_R3;
        `QI_R4A:  entry <= `QV_R4A;
        `QI_R4D:  entry <= `QV_R4D;
        // zero words
        default:  entry <= `QV_ZERO;
      endcase
    end
  end

endmodule
`default_nettype wire
